// *** scd_indicator.sv ***
// One indicator driver: picks the status term for its function and
// blinks it on activity or collision unless status-only is selected.
// Assumes status inputs synchronous to clk and a shared blink phase.
`timescale 1ns/1ps
`default_nettype none

module scd_indicator
	import scd_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Configuration
	input  wire logic [3:0] func,
	input  wire logic       status_only,
	input  wire logic       fiber_combine_off,
	input  wire logic       blink_phase,
	// Link status
	input  wire logic       link_at_10m,
	input  wire logic       link_at_100m,
	input  wire logic       link_at_1000m,
	input  wire logic       fiber_link,
	input  wire logic       copper_activity,
	input  wire logic       fiber_activity,
	input  wire logic       full_duplex,
	input  wire logic       collision,
	// Indicator
	output logic            indicator_q
);

	// ************************************************************
	// Status terms
	// ************************************************************
	// Fiber folds into every link term while combining is on
	wire logic fib_w   = fiber_link & ~fiber_combine_off;
	wire logic act_w   = copper_activity | (fiber_activity & ~fiber_combine_off);
	wire logic l10_w   = link_at_10m | fib_w;
	wire logic l100_w  = link_at_100m | fib_w;
	wire logic l1000_w = link_at_1000m | fib_w;
	logic      cond_w;
	logic      event_w;

	always_comb begin
		cond_w  = 1'b0;
		event_w = act_w;
		case (func)
			SCD_LF_LINK_ACT:         cond_w = l10_w | l100_w | l1000_w;
			SCD_LF_LINK_AT_1000M_ACT:     cond_w = l1000_w;
			SCD_LF_LINK_AT_100M_ACT:      cond_w = l100_w;
			SCD_LF_LINK_AT_10M_ACT:       cond_w = l10_w;
			SCD_LF_LINK_AT_100M_1000_ACT: cond_w = l100_w | l1000_w;
			SCD_LF_LINK_AT_10M_100_ACT:   cond_w = l10_w | l100_w;
			SCD_LF_LINK_AT_10M_1000_ACT:  cond_w = l10_w | l1000_w;
			SCD_LF_DUPLEX_COLL: begin
				cond_w  = full_duplex;
				event_w = collision;
			end
			SCD_LF_ACTIVITY:         cond_w = act_w;
			SCD_LF_FIBER_LINK_ACT: begin
				cond_w  = fiber_link;
				event_w = fiber_activity;
			end
			SCD_LF_FIBER_ACT: begin
				cond_w  = fiber_activity;
				event_w = fiber_activity;
			end
			SCD_LF_COLLISION: begin
				cond_w  = collision;
				event_w = collision;
			end
			SCD_LF_FORCE_ON: begin
				cond_w  = 1'b1;
				event_w = 1'b0;
			end
			default: begin
				cond_w  = 1'b0;
				event_w = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Blink or steady
	// ************************************************************
	// blink on activity
	wire logic on_w = cond_w & ~(~status_only & event_w & ~blink_phase);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			indicator_q <= 1'b0;
		end else begin
			indicator_q <= on_w;
		end
	end

endmodule

`default_nettype wire

// *** scd_params.svh ***
// Constants of the strap configuration decoder: register offsets, field
// positions, reset values and timing figures.
// Assumes a 100 MHz core clock and a 12-bit APB byte address.
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define SCD_OFF_SIGNAL_DETECT_INPUT_CFG   12'h000
`define SCD_OFF_LED_FUNC     12'h004
`define SCD_OFF_LED_MODE     12'h008
`define SCD_OFF_STRAP_STATUS 12'h00c
`define SCD_OFF_STRAP_CODES  12'h010
`define SCD_OFF_LINK_STATE   12'h014

// ************************************************************
// Field positions
// ************************************************************
`define SCD_CODE_RAIL_BIT    3
`define SCD_CODE_POL_BIT     2
`define SCD_CODE_SWAP_BIT    1
`define SCD_CODE_FIBER_BIT   0
`define SCD_MODE_FIBER_BIT   15
`define SCD_POL_PIN          4
`define SCD_STAT_LOADED_BIT  4

// ************************************************************
// Reset values, used until the straps are loaded
// ************************************************************
`define SCD_RST_SIGNAL_DETECT_INPUT_POL   1'b0
`define SCD_RST_LED_FUNC     16'h0000
`define SCD_RST_LED_MODE     16'h0000

// ************************************************************
// Timing
// ************************************************************
`define SCD_CLK_PERIOD_NS    10
`define SCD_SETTLE_NS        100
`define SCD_SETTLE_CYC       ((`SCD_SETTLE_NS + `SCD_CLK_PERIOD_NS - 1) / `SCD_CLK_PERIOD_NS)
`define SCD_BLINK_HALF_NS    50000000
`define SCD_BLINK_HALF_CYC   (`SCD_BLINK_HALF_NS / `SCD_CLK_PERIOD_NS)

`endif

// *** scd_pkg.sv ***
// Types of the strap configuration decoder.
// Assumes nothing of its surroundings.
package scd_pkg;

	// ************************************************************
	// Strap load sequence
	// ************************************************************
	typedef enum logic [1:0] {
		SCD_ST_SETTLE = 2'b00,
		SCD_ST_SAMPLE = 2'b01,
		SCD_ST_LOADED = 2'b11
	} scd_state_t;

	// ************************************************************
	// Indicator functions, one four-bit field per indicator
	// ************************************************************
	typedef enum logic [3:0] {
		SCD_LF_LINK_ACT        = 4'h0,
		SCD_LF_LINK_AT_1000M_ACT    = 4'h1,
		SCD_LF_LINK_AT_100M_ACT     = 4'h2,
		SCD_LF_LINK_AT_10M_ACT      = 4'h3,
		SCD_LF_LINK_AT_100M_1000_ACT = 4'h4,
		SCD_LF_LINK_AT_10M_100_ACT  = 4'h5,
		SCD_LF_LINK_AT_10M_1000_ACT = 4'h6,
		SCD_LF_DUPLEX_COLL     = 4'h7,
		SCD_LF_ACTIVITY        = 4'h8,
		SCD_LF_FIBER_LINK_ACT  = 4'h9,
		SCD_LF_FIBER_ACT       = 4'ha,
		SCD_LF_COLLISION       = 4'hb,
		SCD_LF_FORCE_OFF       = 4'hc,
		SCD_LF_FORCE_ON        = 4'hd
	} scd_led_func_t;

endpackage

// *** scd_strap_board.sv ***
// Board strap model: turns a wanted four-bit code per pin into a rail tie
// and a resistor index. Assumes the bench holds the code steady over reset.
`timescale 1ns/1ps
`default_nettype none
module scd_strap_board #(
	parameter int NUM_PINS = 5
) (
	// Wanted codes, pin 0 in the low nibble
	input  wire logic [4*NUM_PINS-1:0] code,
	// Strap pins
	output logic      [NUM_PINS-1:0]   rail,
	output logic      [3*NUM_PINS-1:0] level
);
	// ********************
	// Strap ties
	// ********************
	// rail and resistor
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			rail[i]        = code[4*i+3];
			level[3*i+:3]  = code[4*i+:3];
		end
	end
endmodule
`default_nettype wire

// *** scd_strap_config.sv ***
// Strap configuration decoder with an APB register slave.
// Assumes strap pins present a rail tie and a resistor level index,
// all inputs synchronous to clk, and an APB master on the same clock.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"

module scd_strap_config
	import scd_pkg::*;
#(
	parameter int SETTLE_CYCLES     = `SCD_SETTLE_CYC,
	parameter int BLINK_HALF_CYCLES = `SCD_BLINK_HALF_CYC,
	parameter int NUM_PINS          = 5,
	parameter int NUM_LEDS          = 4
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Strap pins
	input  wire logic [NUM_PINS-1:0]   config_strap_pin_rail,
	input  wire logic [3*NUM_PINS-1:0] config_strap_pin_level,
	// Management address lookup
	input  wire logic                  mgmt_access_valid,
	input  wire logic [4:0]            mgmt_access_addr,
	output logic                       mgmt_port_hit,
	output logic                       mgmt_port_sel,
	output logic [2:0]                 mgmt_address_high_bits,
	output logic                       port_address_swap,
	// Media status
	input  wire logic                  signal_detect_input,
	input  wire logic                  link_at_10m,
	input  wire logic                  link_at_100m,
	input  wire logic                  link_at_1000m,
	input  wire logic                  fiber_link,
	input  wire logic                  copper_activity,
	input  wire logic                  fiber_activity,
	input  wire logic                  full_duplex,
	input  wire logic                  collision,
	output logic                       fiber_signal_present,
	// Indicators
	output logic                       indicator_zero,
	output logic                       indicator_one,
	output logic                       indicator_two,
	output logic                       indicator_three
);

	// ************************************************************
	// Strap decode
	// ************************************************************
	logic [4*NUM_PINS-1:0] code_w;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			assign code_w[4*gi +: 4] = {config_strap_pin_rail[gi],
				config_strap_pin_level[3*gi +: 3]};
		end
	endgenerate

	// Strap value to indicator function; only four of the register
	// codes are reachable per indicator from the pins
	function automatic logic [3:0] strap_func(input logic [1:0] idx,
		input logic [1:0] sel);
		logic [3:0] f;
		f = SCD_LF_FORCE_OFF;
		unique case ({idx, sel})
			4'h0: f = SCD_LF_LINK_AT_1000M_ACT;
			4'h1: f = SCD_LF_LINK_AT_100M_1000_ACT;
			4'h2: f = SCD_LF_ACTIVITY;
			4'h3: f = SCD_LF_LINK_ACT;
			4'h4: f = SCD_LF_LINK_AT_100M_ACT;
			4'h5: f = SCD_LF_LINK_AT_100M_1000_ACT;
			4'h6: f = SCD_LF_LINK_AT_10M_100_ACT;
			4'h7: f = SCD_LF_FIBER_LINK_ACT;
			4'h8: f = SCD_LF_LINK_ACT;
			4'h9: f = SCD_LF_DUPLEX_COLL;
			4'ha: f = SCD_LF_FIBER_ACT;
			4'hb: f = SCD_LF_LINK_AT_10M_ACT;
			4'hc: f = SCD_LF_DUPLEX_COLL;
			4'hd: f = SCD_LF_LINK_AT_100M_ACT;
			4'he: f = SCD_LF_ACTIVITY;
			4'hf: f = SCD_LF_FIBER_LINK_ACT;
		endcase
		return f;
	endfunction

	wire logic [3:0]  strap_f0_w = strap_func(2'd0, code_w[1:0]);
	wire logic [3:0]  strap_f1_w = strap_func(2'd1, code_w[5:4]);
	wire logic [3:0]  strap_f2_w = strap_func(2'd2, code_w[9:8]);
	wire logic [3:0]  strap_f3_w = strap_func(2'd3, code_w[13:12]);
	wire logic [15:0] strap_func_w = {strap_f3_w, strap_f2_w, strap_f1_w, strap_f0_w};
	wire logic [15:0] strap_mode_w = {code_w[4*`SCD_POL_PIN + `SCD_CODE_FIBER_BIT],
		11'h000, code_w[14], code_w[10], code_w[6], code_w[2]};
	wire logic [2:0]  strap_addr_w = {code_w[11], code_w[7], code_w[3]};

	// ************************************************************
	// Load sequence
	// ************************************************************
	scd_state_t  state_q;
	logic [15:0] settle_q;
	logic [19:0] strap_code_q;
	logic [2:0]  addr_high_q;
	logic        swap_q;

	wire logic settle_done_w = (settle_q >= 16'(SETTLE_CYCLES - 1));
	wire logic loaded_w      = (state_q == SCD_ST_LOADED);
	wire logic sample_w      = (state_q == SCD_ST_SAMPLE);

	// single sample after release; straps are never looked at again
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q  <= SCD_ST_SETTLE;
			settle_q <= 16'h0000;
		end else begin
			unique case (state_q)
				SCD_ST_SETTLE: begin
					settle_q <= settle_q + 16'h0001;
					if (settle_done_w) begin
						state_q <= SCD_ST_SAMPLE;
					end
				end
				SCD_ST_SAMPLE: state_q <= SCD_ST_LOADED;
				SCD_ST_LOADED: state_q <= SCD_ST_LOADED;
				default:       state_q <= SCD_ST_SETTLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_code_q <= 20'h00000;
			addr_high_q  <= 3'h0;
			swap_q       <= 1'b0;
		end else if (sample_w) begin
			strap_code_q <= code_w;
			addr_high_q  <= strap_addr_w;
			swap_q       <= code_w[4*`SCD_POL_PIN + `SCD_CODE_SWAP_BIT];
		end
	end

	// ************************************************************
	// APB decode
	// ************************************************************
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        signal_detect_input_pol_q;
	logic [15:0] led_func_q;
	logic [15:0] led_mode_q;
	logic        sig_present_q;
	logic [NUM_LEDS-1:0] ind_w;

	wire logic sel_sig_w  = (paddr == `SCD_OFF_SIGNAL_DETECT_INPUT_CFG);
	wire logic sel_func_w = (paddr == `SCD_OFF_LED_FUNC);
	wire logic sel_mode_w = (paddr == `SCD_OFF_LED_MODE);
	wire logic sel_stat_w = (paddr == `SCD_OFF_STRAP_STATUS);
	wire logic sel_code_w = (paddr == `SCD_OFF_STRAP_CODES);
	wire logic sel_link_w = (paddr == `SCD_OFF_LINK_STATE);
	wire logic mapped_w   = sel_sig_w | sel_func_w | sel_mode_w | sel_stat_w |
		sel_code_w | sel_link_w;

	// Wait states hold the master off until defaults are loaded, so no
	// write can be lost under the strap load
	wire logic accept_w = psel & penable & ~pready_q & loaded_w;
	wire logic commit_w = psel & penable & pready_q & pwrite & ~pslverr_q;
	wire logic wr_sig_w  = commit_w & sel_sig_w & pstrb[0];
	wire logic wr_func_w = commit_w & sel_func_w;
	wire logic wr_mode_w = commit_w & sel_mode_w;

	wire logic [15:0] wmask_w = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire logic [15:0] func_d  = (led_func_q & ~wmask_w) | (pwdata[15:0] & wmask_w);
	wire logic [15:0] mode_d  = ((led_mode_q & ~wmask_w) | (pwdata[15:0] & wmask_w)) &
		16'h800f;

	wire logic [31:0] rdata_w =
		sel_sig_w  ? {31'h00000000, signal_detect_input_pol_q} :
		sel_func_w ? {16'h0000, led_func_q} :
		sel_mode_w ? {16'h0000, led_mode_q} :
		sel_stat_w ? {27'h0000000, loaded_w, swap_q, addr_high_q} :
		sel_code_w ? {12'h000, strap_code_q} :
		sel_link_w ? {27'h0000000, sig_present_q, ind_w} :
		32'h00000000;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= accept_w;
			pslverr_q <= accept_w & ~mapped_w;
			if (accept_w && !pwrite) begin
				prdata_q <= rdata_w;
			end
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	// polarity default
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			signal_detect_input_pol_q <= `SCD_RST_SIGNAL_DETECT_INPUT_POL;
		end else if (sample_w) begin
			signal_detect_input_pol_q <= code_w[4*`SCD_POL_PIN + `SCD_CODE_POL_BIT];
		end else if (wr_sig_w) begin
			signal_detect_input_pol_q <= pwdata[0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			led_func_q <= `SCD_RST_LED_FUNC;
			led_mode_q <= `SCD_RST_LED_MODE;
		end else if (sample_w) begin
			led_func_q <= strap_func_w;
			led_mode_q <= strap_mode_w;
		end else begin
			if (wr_func_w) begin
				led_func_q <= func_d;
			end
			if (wr_mode_w) begin
				led_mode_q <= mode_d;
			end
		end
	end

	// ************************************************************
	// Signal detect and address lookup
	// ************************************************************
	logic port_hit_q;
	logic port_sel_q;

	wire logic sig_present_d = signal_detect_input ^ signal_detect_input_pol_q;
	wire logic addr_hit_w = mgmt_access_valid & loaded_w &
		(mgmt_access_addr[4:2] == addr_high_q) & ~mgmt_access_addr[1];
	wire logic port_d = mgmt_access_addr[0] ^ swap_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sig_present_q <= 1'b0;
			port_hit_q    <= 1'b0;
			port_sel_q    <= 1'b0;
		end else begin
			sig_present_q <= sig_present_d;
			port_hit_q    <= addr_hit_w;
			port_sel_q    <= port_d;
		end
	end

	// ************************************************************
	// Indicators
	// ************************************************************
	logic [31:0] blink_cnt_q;
	logic        blink_q;

	// One phase for all indicators keeps their blinking in step
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			blink_cnt_q <= 32'h00000000;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q >= 32'(BLINK_HALF_CYCLES - 1)) begin
			blink_cnt_q <= 32'h00000000;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h00000001;
		end
	end

	generate
		for (gi = 0; gi < NUM_LEDS; gi++) begin : g_led
			scd_indicator u_ind (
				.clk               (clk),
				.rst_b             (rst_b),
				.func              (led_func_q[4*gi +: 4]),
				.status_only       (led_mode_q[gi]),
				.fiber_combine_off (led_mode_q[`SCD_MODE_FIBER_BIT]),
				.blink_phase       (blink_q),
				.link_at_10m       (link_at_10m),
				.link_at_100m      (link_at_100m),
				.link_at_1000m     (link_at_1000m),
				.fiber_link        (fiber_link),
				.copper_activity   (copper_activity),
				.fiber_activity    (fiber_activity),
				.full_duplex       (full_duplex),
				.collision         (collision),
				.indicator_q       (ind_w[gi])
			);
		end
	endgenerate

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata                 = prdata_q;
	assign pready                 = pready_q;
	assign pslverr                = pslverr_q;
	assign mgmt_port_hit          = port_hit_q;
	assign mgmt_port_sel          = port_sel_q;
	assign mgmt_address_high_bits = addr_high_q;
	assign port_address_swap      = swap_q;
	assign fiber_signal_present   = sig_present_q;
	assign indicator_zero         = ind_w[0];
	assign indicator_one          = ind_w[1];
	assign indicator_two          = ind_w[2];
	assign indicator_three        = ind_w[3];

endmodule

`default_nettype wire

// *** scd_strap_props.sv ***
// Checker for the strap decoder ports: strap load, address lookup, APB.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module scd_strap_props #(
	parameter int NUM_PINS = 5
) (
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  rst_b,
	// APB
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// Straps and lookup
	input wire logic [NUM_PINS-1:0]   config_strap_pin_rail,
	input wire logic [3*NUM_PINS-1:0] config_strap_pin_level,
	input wire logic                  mgmt_access_valid,
	input wire logic [4:0]            mgmt_access_addr,
	input wire logic                  mgmt_port_hit,
	input wire logic                  mgmt_port_sel,
	input wire logic [2:0]            mgmt_address_high_bits,
	input wire logic                  port_address_swap
);
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Swap must be steady, a lookup taken on the load edge sees the old one
	sel_map_a:
	assert property (mgmt_access_valid ##1 $stable(port_address_swap) |->
		mgmt_port_sel == ($past(mgmt_access_addr[0]) ^ port_address_swap))
		else $error("port select wrong");
	hit_match_a:
	assert property (mgmt_port_hit |-> $past(mgmt_access_valid) && !$past(mgmt_access_addr[1])
		&& $past(mgmt_access_addr[4:2]) == mgmt_address_high_bits)
		else $error("address hit wrong");
	high_bits_a:
	assert property ($changed(mgmt_address_high_bits) |-> mgmt_address_high_bits ==
		{config_strap_pin_rail[2], config_strap_pin_rail[1], config_strap_pin_rail[0]})
		else $error("high address bits wrong");
	swap_load_a:
	assert property ($changed(port_address_swap) |->
		port_address_swap == config_strap_pin_level[13])
		else $error("swap load wrong");
	ready_pulse_a:
	assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	ready_access_a:
	assert property (pready |-> psel && penable)
		else $error("ready outside access");
	// A refused write leaves the last read data standing on the bus
	err_ready_a:
	assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
		else $error("error response malformed");
	ready_bound_a:
	assert property (psel && penable && !pready |-> ##[1:40] pready)
		else $error("access never ended");
endmodule

bind scd_strap_config scd_strap_props #(.NUM_PINS(NUM_PINS)) u_props (
	.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .config_strap_pin_rail(config_strap_pin_rail),
	.config_strap_pin_level(config_strap_pin_level), .mgmt_access_valid(mgmt_access_valid),
	.mgmt_access_addr(mgmt_access_addr), .mgmt_port_hit(mgmt_port_hit),
	.mgmt_port_sel(mgmt_port_sel), .mgmt_address_high_bits(mgmt_address_high_bits),
	.port_address_swap(port_address_swap));
`default_nettype wire

// *** strap_config_decoder_tb_top.sv ***
// Self-checking bench for the strap decoder: strap rounds, lookup, APB.
// Assumes the board model drives the straps and media inputs run random.
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"
module strap_config_decoder_tb_top;
	localparam logic [63:0] LMAP = 64'h9827_3a70_9542_0841;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, valid, hit, sel, sd, pol;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, wv;
	logic [19:0] code, c0;
	logic [14:0] level;
	logic [7:0]  media, m0;
	logic [4:0]  rail, maddr;
	logic [3:0]  ind;
	logic [2:0]  hi;
	logic        err, swp, fsp;
	int          err_total, compares;

	scd_strap_board u_board (.code(code), .rail(rail), .level(level));
	scd_strap_config #(.BLINK_HALF_CYCLES(4)) dut (
		.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .config_strap_pin_rail(rail), .config_strap_pin_level(level),
		.mgmt_access_valid(valid), .mgmt_access_addr(maddr), .mgmt_port_hit(hit),
		.mgmt_port_sel(sel), .mgmt_address_high_bits(), .port_address_swap(),
		.signal_detect_input(sd), .link_at_10m(media[0]), .link_at_100m(media[1]),
		.link_at_1000m(media[2]), .fiber_link(media[3]), .copper_activity(media[4]),
		.fiber_activity(media[5]), .full_duplex(media[6]), .collision(media[7]),
		.fiber_signal_present(fsp), .indicator_zero(ind[0]), .indicator_one(ind[1]),
		.indicator_two(ind[2]), .indicator_three(ind[3]));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Media inputs toggle freely so the indicator logic sees traffic
	always @(posedge clk) media <= 8'($urandom);

	// ********************
	// Helpers
	// ********************
	task automatic results();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 100) begin
			err_total++;
			results();
		end
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic mchk(input logic [4:0] a, input logic eh, input logic es);
		valid <= 1'b1;
		maddr <= a;
		repeat (2) @(posedge clk);
		chk("port hit", eh, hit);
		chk("port select", es, sel);
	endtask
	function automatic logic [31:0] exp_func(input logic [19:0] c);
		logic [31:0] f;
		f = 32'h0;
		for (int i = 0; i < 4; i++) f[4*i+:4] = LMAP[16*i+4*c[4*i+:2]+:4];
		return f;
	endfunction
	// Steady indicators for functions 8, 7, 9 and 0 on indicators zero to three
	function automatic logic [3:0] exp_ind(input logic [7:0] m, input logic off);
		return {|m[2:0] | (m[3] & ~off), m[3], m[6], m[4] | (m[5] & ~off)};
	endfunction

	// ********************
	// Main sequence
	// ********************
	initial begin
		{rst_b, psel, penable, pwrite, valid, sd, paddr, pwdata, maddr, code} = '0;
		err_total = 0;
		compares = 0;
		rd = $urandom(59041);
		for (int r = 0; r < 4; r++) begin
			// Rounds 0 and 3 are the all-ground and all-high boards
			c0 = (r == 0) ? 20'h0 : (r == 3) ? 20'hfffff : 20'($urandom);
			for (int i = 0; i < 4; i++) c0[4*i+:2] = 2'(r);
			code <= c0;
			rst_b <= 1'b0;
			repeat (12) @(posedge clk);
			rst_b <= 1'b1;
			hi = {c0[11], c0[7], c0[3]};
			swp = c0[17];
			pol = c0[18];
			rchk("codes", `SCD_OFF_STRAP_CODES, {12'h0, c0});
			rchk("status", `SCD_OFF_STRAP_STATUS, {27'h0, 1'b1, swp, hi});
			rchk("polarity", `SCD_OFF_SIGNAL_DETECT_INPUT_CFG, {31'h0, pol});
			rchk("led func", `SCD_OFF_LED_FUNC, exp_func(c0));
			rchk("led mode", `SCD_OFF_LED_MODE,
				{16'h0, c0[16], 11'h0, c0[14], c0[10], c0[6], c0[2]});
			for (int b = 0; b < 2; b++) begin
				mchk({hi, 1'b0, 1'(b)}, 1'b1, 1'(b) ^ swp);
				mchk({hi, 1'b1, 1'(b)}, 1'b0, 1'(b) ^ swp);
				mchk({~hi, 1'b0, 1'(b)}, 1'b0, 1'(b) ^ swp);
			end
			valid <= 1'b0;
			code <= ~c0;
			repeat (20) @(posedge clk);
			rchk("codes held", `SCD_OFF_STRAP_CODES, {12'h0, c0});
			for (int k = 0; k < 2; k++) begin
				if (k == 1) apb(1'b1, `SCD_OFF_SIGNAL_DETECT_INPUT_CFG, {31'h0, ~pol});
				sd <= ~sd;
				repeat (2) @(posedge clk);
				apb(1'b0, `SCD_OFF_LINK_STATE, 32'h0);
				chk("signal present", {31'h0, sd ^ pol ^ 1'(k)}, {31'h0, rd[4]});
				chk("signal pin", {31'h0, sd ^ pol ^ 1'(k)}, {31'h0, fsp});
			end
			wv = $urandom;
			apb(1'b1, `SCD_OFF_LED_FUNC, wv);
			rchk("func write", `SCD_OFF_LED_FUNC, {16'h0, wv[15:0]});
			apb(1'b1, `SCD_OFF_LED_MODE, ~wv);
			rchk("mode write", `SCD_OFF_LED_MODE, ~wv & 32'h800f);
			// Status-only indicators, fiber combined first and then copper only
			apb(1'b1, `SCD_OFF_LED_FUNC, 32'h0978);
			for (int f = 0; f < 2; f++) begin
				apb(1'b1, `SCD_OFF_LED_MODE, {16'h0, 1'(f), 11'h0, 4'hf});
				for (int t = 0; t < 8; t++) begin
					m0 = media;
					@(posedge clk);
					chk("indicators", {28'h0, exp_ind(m0, 1'(f))}, {28'h0, ind});
				end
			end
			apb(1'b1, `SCD_OFF_STRAP_STATUS, 32'hffffffff);
			rchk("status ro", `SCD_OFF_STRAP_STATUS, {27'h0, 1'b1, swp, hi});
			apb(1'b0, 12'h020, 32'h0);
			chk("unmapped error", 32'h1, {31'h0, err});
			chk("unmapped data", 32'h0, rd);
			$display("test round %0d done", r);
		end
		results();
	end
endmodule
`default_nettype wire
